// >>> logic/pulse_timer_unit_pkg.sv
/*
  Constants for the multichannel pulse timer: register map, field
  positions, reset values, prescaler counts and mode encodings.
  Assumes an APB slave with 32-bit data and one word per register.
*/
`default_nettype none

package pulse_timer_unit_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int NUM_CHAN_DEF = 6;
    localparam int CNT_W_DEF    = 16;
    localparam int CMP_PER_CHAN = 4;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] RUN_OFS   = 12'h000; // counter_run_select
    localparam logic [11:0] SYNC_OFS  = 12'h004; // sync_group_select
    localparam int          CHAN_BIT  = 8;       // Channel window flag bit
    localparam logic [2:0]  CTRL_IDX  = 3'h0;    // chanN_control
    localparam logic [2:0]  MODE_IDX  = 3'h1;    // chanN_mode_select
    localparam logic [2:0]  LVL_IDX   = 3'h2;    // chanN_pin_level_control
    localparam logic [2:0]  CNT_IDX   = 3'h3;    // Channel counter
    localparam logic [2:0]  CMP_IDX   = 3'h4;    // First general compare, +1 each

    // ------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------
    localparam int CLK_LSB = 0;
    localparam int CLR_LSB = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0]  CTRL_RST = 4'h0;
    localparam logic [1:0]  MODE_RST = 2'h0;
    localparam logic [7:0]  LVL_RST  = 8'h00;
    localparam logic [15:0] CMP_RST  = 16'hffff;
    localparam logic [15:0] CNT_RST  = 16'h0000;

    // ------------------------------------------------------------
    // Prescaler: enables for pclk/4 and pclk/16
    // ------------------------------------------------------------
    localparam logic [3:0] DIV4_MASK = 4'h3;
    localparam logic [3:0] DIV16_END = 4'hf;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {CLK_PCLK = 2'h0, CLK_DIV4 = 2'h1,
                              CLK_DIV16 = 2'h3, CLK_CASCADE = 2'h2} clk_sel_e;
    typedef enum logic [1:0] {CLR_NONE = 2'h0, CLR_A = 2'h1,
                              CLR_B = 2'h3, CLR_SYNC = 2'h2} clr_sel_e;
    typedef enum logic [1:0] {MODE_NORMAL = 2'h0, MODE_PWM1 = 2'h1,
                              MODE_PWM2 = 2'h3, MODE_RSVD = 2'h2} mode_e;
    typedef enum logic [1:0] {ACT_NONE = 2'h0, ACT_LOW = 2'h1,
                              ACT_HIGH = 2'h2, ACT_TOGGLE = 2'h3} pin_act_e;

endpackage

`default_nettype wire

// >>> logic/pulse_timer_unit.sv
/*
  Multichannel 16-bit pulse timer with cascade, PWM pair mode and
  synchronous-clear PWM mode, programmed over APB.
  Assumes a single 25 MHz pclk, asynchronous active-low presetn and
  an APB master that holds each request until pready.
*/
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Two 16-bit channel counters can be joined into one 32-bit counter.
// - In cascade the first channel holds upper half, second the lower.
// - Cascaded upper counter advances once per lower counter wraparound.
// - Pair mode drives one output from first and second compare registers.
// - Compare matches change output pins in hardware, no software per edge.
// - Long-cycle output covers 0% to 100% duty in 1/65,536 steps.
// - Synchronous shared-cycle mode yields up to twenty-three PWM phases.
// - Control can pick first compare match as the counter clear source.
// - Synchronous-clear channels clear whenever a group member clears.
// - In shared-cycle mode a duty compare match drives its pin high.
// - Sync group register selects, one bit per channel, who joins.
// - Run register starts and stops each channel counter independently.
// - Channel control selects count clock and counter clear source.
// - Pin level control sets the level each pin takes on a match.
// - In pair mode third and fourth compares pair for a second output.
module pulse_timer_unit #(
    parameter int NUM_CHAN = pulse_timer_unit_pkg::NUM_CHAN_DEF
) (
    input  wire logic                  pclk,    // 25 MHz clock
    input  wire logic                  presetn, // Async reset, active low
    input  wire logic                  psel,    // APB select
    input  wire logic                  penable, // APB access phase
    input  wire logic                  pwrite,  // APB write
    input  wire logic [11:0]           paddr,   // APB byte address
    input  wire logic [31:0]           pwdata,  // APB write data
    output logic      [31:0]           prdata,  // APB read data
    output logic                       pready,  // APB ready
    output logic                       pslverr, // Unmapped address
    output logic      [4*NUM_CHAN-1:0] pwm_pin  // Four pins per channel
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [NUM_CHAN-1:0] run;
    logic [NUM_CHAN-1:0] next_run;
    logic [NUM_CHAN-1:0] sync_sel;
    logic [NUM_CHAN-1:0] next_sync_sel;
    logic [3:0]          ctrl      [NUM_CHAN];
    logic [3:0]          next_ctrl [NUM_CHAN];
    logic [1:0]          mode      [NUM_CHAN];
    logic [1:0]          next_mode [NUM_CHAN];
    logic [7:0]          lvl       [NUM_CHAN];
    logic [7:0]          next_lvl  [NUM_CHAN];
    logic [15:0]         cmp       [NUM_CHAN][4];
    logic [15:0]         next_cmp  [NUM_CHAN][4];
    logic [15:0]         cnt       [NUM_CHAN];
    logic [3:0]          pin_q     [NUM_CHAN];
    logic [3:0]          div_cnt;
    logic                div4_en;
    logic                div16_en;
    logic [NUM_CHAN-1:0] tick;
    logic [NUM_CHAN-1:0] ovf;
    logic [NUM_CHAN-1:0] own_clr;
    logic [NUM_CHAN-1:0] clr_now;
    logic [NUM_CHAN-1:0] cnt_wr;
    logic [4*NUM_CHAN-1:0] match_v;
    logic                group_clr;
    logic                access;
    logic                wr_en;
    logic                chan_hit;
    logic                mapped;
    logic [2:0]          ch;
    logic [2:0]          idx;
    logic [31:0]         rd_val;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    // One wait state so that read data and ready come from flops
    assign access   = psel & penable;
    assign wr_en    = access & pwrite & pready;
    assign ch       = paddr[7:5];
    assign idx      = paddr[4:2];
    assign chan_hit = paddr[pulse_timer_unit_pkg::CHAN_BIT] && paddr[11:9] == 3'h0
                      && 32'(ch) < NUM_CHAN;
    assign mapped   = chan_hit || paddr == pulse_timer_unit_pkg::RUN_OFS
                      || paddr == pulse_timer_unit_pkg::SYNC_OFS;

    // Read mux; unmapped and reserved bits read as zero
    always_comb begin
        rd_val = 32'h0000_0000;
        if (paddr == pulse_timer_unit_pkg::RUN_OFS) begin
            rd_val[NUM_CHAN-1:0] = run;
        end else if (paddr == pulse_timer_unit_pkg::SYNC_OFS) begin
            rd_val[NUM_CHAN-1:0] = sync_sel;
        end else if (chan_hit) begin
            unique case (idx)
                pulse_timer_unit_pkg::CTRL_IDX: rd_val[3:0]  = ctrl[ch];
                pulse_timer_unit_pkg::MODE_IDX: rd_val[1:0]  = mode[ch];
                pulse_timer_unit_pkg::LVL_IDX:  rd_val[7:0]  = lvl[ch];
                pulse_timer_unit_pkg::CNT_IDX:  rd_val[15:0] = cnt[ch];
                default:                        rd_val[15:0] = cmp[ch][idx[1:0]];
            endcase
        end
    end

    // Bus response flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= access & ~pready;
            prdata  <= (access & ~pready & ~pwrite) ? rd_val : 32'h0000_0000;
            pslverr <= access & ~pready & ~mapped;
        end
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    // Next values of software-owned registers
    always_comb begin
        next_run      = run;
        next_sync_sel = sync_sel;
        next_ctrl     = ctrl;
        next_mode     = mode;
        next_lvl      = lvl;
        next_cmp      = cmp;
        if (wr_en && paddr == pulse_timer_unit_pkg::RUN_OFS) begin
            next_run = pwdata[NUM_CHAN-1:0];
        end
        if (wr_en && paddr == pulse_timer_unit_pkg::SYNC_OFS) begin
            next_sync_sel = pwdata[NUM_CHAN-1:0];
        end
        if (wr_en && chan_hit) begin
            unique case (idx)
                pulse_timer_unit_pkg::CTRL_IDX: next_ctrl[ch] = pwdata[3:0];
                pulse_timer_unit_pkg::MODE_IDX: next_mode[ch] = pwdata[1:0];
                pulse_timer_unit_pkg::LVL_IDX:  next_lvl[ch]  = pwdata[7:0];
                pulse_timer_unit_pkg::CNT_IDX:  next_run      = run;
                default: next_cmp[ch][idx[1:0]] = pwdata[15:0];
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run      <= '0;
            sync_sel <= '0;
            for (int i = 0; i < NUM_CHAN; i++) begin
                ctrl[i] <= pulse_timer_unit_pkg::CTRL_RST;
                mode[i] <= pulse_timer_unit_pkg::MODE_RST;
                lvl[i]  <= pulse_timer_unit_pkg::LVL_RST;
                for (int k = 0; k < 4; k++) begin
                    cmp[i][k] <= pulse_timer_unit_pkg::CMP_RST;
                end
            end
        end else begin
            run      <= next_run;
            sync_sel <= next_sync_sel;
            ctrl     <= next_ctrl;
            mode     <= next_mode;
            lvl      <= next_lvl;
            cmp      <= next_cmp;
        end
    end

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    // Free-running divider gives one-cycle enables for slow count clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 4'h0;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end
    assign div4_en  = (div_cnt & pulse_timer_unit_pkg::DIV4_MASK)
                      == pulse_timer_unit_pkg::DIV4_MASK;
    assign div16_en = div_cnt == pulse_timer_unit_pkg::DIV16_END;

    // Synchronous group clears when a member clears on its own source
    assign group_clr = |(own_clr & sync_sel);

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
        logic        casc_in;
        logic        src;
        logic [3:0]  mt;
        logic [15:0] next_cnt;
        logic [3:0]  next_pin;
        logic [1:0]  clk_sel;
        logic [1:0]  clr_sel;

        // Only the next channel up may feed the cascade, so no ring forms
        if (g + 1 < NUM_CHAN) begin : g_casc
            assign casc_in = ovf[g+1];
        end else begin : g_nocasc
            assign casc_in = 1'b0;
        end

        assign clk_sel = ctrl[g][pulse_timer_unit_pkg::CLK_LSB +: 2];
        assign clr_sel = ctrl[g][pulse_timer_unit_pkg::CLR_LSB +: 2];

        // Count clock selection
        always_comb begin
            unique case (clk_sel)
                pulse_timer_unit_pkg::CLK_PCLK:  src = 1'b1;
                pulse_timer_unit_pkg::CLK_DIV4:  src = div4_en;
                pulse_timer_unit_pkg::CLK_DIV16: src = div16_en;
                default:                         src = casc_in;
            endcase
        end
        assign tick[g] = run[g] & src;

        for (genvar k = 0; k < 4; k++) begin : g_cmp
            assign mt[k] = tick[g] && cnt[g] == cmp[g][k];
        end
        assign match_v[4*g +: 4] = mt;

        // Own clear on first or second compare match
        assign own_clr[g] = (clr_sel == pulse_timer_unit_pkg::CLR_A & mt[0])
                          | (clr_sel == pulse_timer_unit_pkg::CLR_B & mt[1]);
        assign clr_now[g] = own_clr[g] | (clr_sel == pulse_timer_unit_pkg::CLR_SYNC
                          & sync_sel[g] & group_clr);
        assign ovf[g]     = tick[g] & (&cnt[g]) & ~clr_now[g];
        assign cnt_wr[g]  = wr_en && chan_hit && 32'(ch) == g
                            && idx == pulse_timer_unit_pkg::CNT_IDX;

        // Counter: software write wins over clear and count
        always_comb begin
            next_cnt = cnt[g];
            if (cnt_wr[g]) begin
                next_cnt = pwdata[15:0];
            end else if (clr_now[g]) begin
                next_cnt = 16'h0000;
            end else if (tick[g]) begin
                next_cnt = cnt[g] + 16'h0001;
            end
        end

        // Pins change on matches and, in shared-cycle mode, on clears; later action in a pair wins
        always_comb begin
            next_pin = pin_q[g];
            unique case (mode[g])
                pulse_timer_unit_pkg::MODE_PWM1: begin
                    for (int p = 0; p < 2; p++) begin
                        if (mt[2*p]) begin
                            next_pin[2*p] = act(lvl[g][4*p +: 2], next_pin[2*p]);
                        end
                        if (mt[2*p+1]) begin
                            next_pin[2*p] = act(lvl[g][4*p+2 +: 2], next_pin[2*p]);
                        end
                    end
                end
                pulse_timer_unit_pkg::MODE_PWM2: begin
                    for (int k = 0; k < 4; k++) begin
                        if ((k == 0 && clr_sel == pulse_timer_unit_pkg::CLR_A)
                            || (k == 1 && clr_sel == pulse_timer_unit_pkg::CLR_B)) begin
                            next_pin[k] = 1'b0; // Cycle register has no output
                        end else if (clr_now[g]) begin
                            next_pin[k] = 1'b0;
                        end else if (mt[k]) begin
                            next_pin[k] = 1'b1;
                        end
                    end
                end
                default: begin
                    for (int k = 0; k < 4; k++) begin
                        if (mt[k]) begin
                            next_pin[k] = act(lvl[g][2*k +: 2], pin_q[g][k]);
                        end
                    end
                end
            endcase
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cnt[g]   <= pulse_timer_unit_pkg::CNT_RST;
                pin_q[g] <= 4'h0;
            end else begin
                cnt[g]   <= next_cnt;
                pin_q[g] <= next_pin;
            end
        end
        assign pwm_pin[4*g +: 4] = pin_q[g];
    end

    // Level that a pin takes for a programmed action
    function automatic logic act(input logic [1:0] a, input logic cur);
        unique case (pulse_timer_unit_pkg::pin_act_e'(a))
            pulse_timer_unit_pkg::ACT_NONE: act = cur;
            pulse_timer_unit_pkg::ACT_LOW:  act = 1'b0;
            pulse_timer_unit_pkg::ACT_HIGH: act = 1'b1;
            default:                        act = ~cur;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Assertions (channel 1 upper, channel 2 lower when cascaded)
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    casc_step_a: assert property (
        (ctrl[1][1:0] == pulse_timer_unit_pkg::CLK_CASCADE)
        && run[1] && ovf[2] && !clr_now[1] && !cnt_wr[1]
        |=> cnt[1] == $past(cnt[1]) + 16'h0001) else $error("upper did not step");
    casc_hold_a: assert property (
        (ctrl[1][1:0] == pulse_timer_unit_pkg::CLK_CASCADE)
        && !ovf[2] && !cnt_wr[1] && !clr_now[1]
        |=> $stable(cnt[1])) else $error("upper moved without carry");
    wrap_zero_a: assert property (
        tick[2] && cnt[2] == 16'hffff && !clr_now[2]
        && !cnt_wr[2] |-> ovf[2] ##1 cnt[2] == 16'h0000)
        else $error("lower did not wrap");
    run_stop_a: assert property (
        !run[0] && !cnt_wr[0] |=> $stable(cnt[0]))
        else $error("stopped counter moved");
    clear_match_a: assert property (
        own_clr[0] && !cnt_wr[0] |=> cnt[0] == 16'h0000)
        else $error("match clear missed");
    sync_clear_a: assert property (
        group_clr && sync_sel[1] && !cnt_wr[1]
        && ctrl[1][3:2] == pulse_timer_unit_pkg::CLR_SYNC |=> cnt[1] == 16'h0000)
        else $error("sync clear missed");
    pwm2_high_a: assert property (
        mode[0] == pulse_timer_unit_pkg::MODE_PWM2
        && ctrl[0][3:2] == pulse_timer_unit_pkg::CLR_A && match_v[1] && !clr_now[0]
        |=> pwm_pin[1]) else $error("duty match not high");
    pwm2_low_a: assert property (
        mode[0] == pulse_timer_unit_pkg::MODE_PWM2
        && clr_now[0] |=> !pwm_pin[1] && !pwm_pin[2] && !pwm_pin[3])
        else $error("cycle clear not low");
    pwm1_pair_a: assert property (
        mode[3] == pulse_timer_unit_pkg::MODE_PWM1
        && match_v[13] && lvl[3][3:2] == pulse_timer_unit_pkg::ACT_LOW
        |=> !pwm_pin[12]) else $error("pair second level wrong");
    apb_ready_a: assert property (access && !pready |=> pready ##1 !pready)
        else $error("ready not one wait state");

    cascade_c: cover property (ovf[2] && ctrl[1][1:0] == pulse_timer_unit_pkg::CLK_CASCADE);
    sync_c:    cover property (group_clr && sync_sel[1]);
    pwm1_c:    cover property (mode[3] == pulse_timer_unit_pkg::MODE_PWM1 && match_v[12]);
    pwm2_c:    cover property (mode[0] == pulse_timer_unit_pkg::MODE_PWM2 && clr_now[0]);

endmodule // pulse_timer_unit

`default_nettype wire

// >>> test/tb_top.sv
/*
  Self-checking bench for the pulse timer: APB access tasks, reset and
  map checks, PWM waveform measurement over a fixed window, and a run
  of the cascaded pair.
  Assumes the design package and pulse_timer_unit are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;

    // ------------------------------------------------------------
    // Signals and bookkeeping
    // ------------------------------------------------------------
    logic        pclk      = 1'b0;
    logic        presetn   = 1'b0;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [11:0] paddr     = 12'h000;
    logic [31:0] pwdata    = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [23:0] pwm_pin;
    logic [31:0] rd;
    logic        se;
    int          err_total = 0;
    int          cmp_count = 0;
    int          cycles    = 0;
    int          hi [24];
    int          rs [24];
    int          eh [24]   = '{default: 0};
    int          er [24]   = '{default: 0};
    // Setup writes {address, data}: ch0 sets the shared cycle, ch1 follows by sync
    // clear, ch2 toggles on pclk/16, ch3 runs pair mode, ch4 toggles on pclk/4,
    // ch5 is configured but stopped
    logic [27:0] cfg [26]  = '{
        {12'h100, 16'h0004}, {12'h104, 16'h0003}, {12'h110, 16'h0009}, {12'h114, 16'h0004},
        {12'h120, 16'h0008}, {12'h124, 16'h0003}, {12'h130, 16'h0006}, {12'h134, 16'h0002},
        {12'h140, 16'h0007}, {12'h148, 16'h0003}, {12'h150, 16'h0000},
        {12'h160, 16'h000c}, {12'h164, 16'h0001}, {12'h168, 16'h0066}, {12'h170, 16'h0002},
        {12'h174, 16'h0007}, {12'h178, 16'h0005}, {12'h17c, 16'h0007}, {12'h180, 16'h0005},
        {12'h188, 16'h0003}, {12'h190, 16'h0001}, {12'h1a0, 16'h0004}, {12'h1a8, 16'h0003},
        {12'h1b0, 16'h0001}, {12'h004, 16'h0003}, {12'h000, 16'h001f}};

    // Clock, 40 ns period
    always #20 pclk = ~pclk;

    pulse_timer_unit dut (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .pwm_pin (pwm_pin)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; values read right after the edge are those sampled at it
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        // Ready is due in the second access cycle; the bench timeout ends a hang
        chk("ready wait", 32'h2, n);
        rd = prdata;
        se = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask

    // High cycles and rising edges of every pin over n cycles
    task automatic measure(input int n);
        logic [23:0] prev;
        @(posedge pclk);
        prev = pwm_pin;
        for (int i = 0; i < 24; i++) begin
            hi[i] = 0;
            rs[i] = 0;
        end
        repeat (n) begin
            @(posedge pclk);
            for (int i = 0; i < 24; i++) begin
                hi[i] += int'(pwm_pin[i]);
                rs[i] += int'(pwm_pin[i] & ~prev[i]);
            end
            prev = pwm_pin;
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Hang guard: the tests need well under a thousand cycles
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            err_total++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        // Shared cycle 10: duties 5, 3, 7; pair period 8: duties 5, 2; toggles every 8, 16
        eh[1] = 80;  er[1] = 16;  eh[4] = 48;   er[4] = 16;  eh[5] = 112; er[5] = 16;
        eh[8] = 80;  er[8] = 5;
        eh[12] = 100; er[12] = 20; eh[14] = 40; er[14] = 20; eh[16] = 80; er[16] = 10;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("run reg", 12'h000, 32'h0);
        rdchk("cmp a0", 12'h110, {16'h0, pulse_timer_unit_pkg::CMP_RST});
        rdchk("cnt0", 12'h10c, {16'h0, pulse_timer_unit_pkg::CNT_RST});
        rdchk("level0", 12'h108, {24'h0, pulse_timer_unit_pkg::LVL_RST});
        rdchk("unmapped", 12'h1c0, 32'h0);
        chk("slverr", 32'h1, {31'h0, se});
        foreach (cfg[i]) apb(1'b1, cfg[i][27:16], {16'h0, cfg[i][15:0]});
        foreach (cfg[i]) rdchk("cfg", cfg[i][27:16], {16'h0, cfg[i][15:0]});
        measure(160);
        chk("pins known", 32'h0, {31'h0, $isunknown(pwm_pin)});
        // Odd pins of the pair-mode channel carry no pair output and stay low
        for (int i = 0; i < 24; i++) begin
            chk($sformatf("pin%0d high", i), eh[i], hi[i]);
            chk($sformatf("pin%0d rises", i), er[i], rs[i]);
        end
        rdchk("stopped cnt", 12'h1ac, 32'h0);
        // Cascade: ch2 starts three below wrap, ch1 counts its overflow
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h120, 32'h2);
        apb(1'b1, 12'h124, 32'h0);
        apb(1'b1, 12'h12c, 32'h0);
        apb(1'b1, 12'h140, 32'h0);
        apb(1'b1, 12'h14c, 32'hfffd);
        apb(1'b1, 12'h000, 32'h6);
        repeat (10) @(posedge pclk);
        apb(1'b1, 12'h000, 32'h0);
        rdchk("upper half", 12'h12c, 32'h1);
        // Fourteen lower ticks from the start edge to the stop edge
        rdchk("lower half", 12'h14c, 32'h0000_000b);
        give_verdict();
    end

endmodule // tb_top

`default_nettype wire
